/* File: src/drive_security_lock_fsm.sv */
// security lock state machine with its register slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "lock_cfg.svh"

module drive_security_lock_fsm (
  input  wire logic             CLK_SYS,
  input  wire logic             RESET,
  input  wire logic             POWER_CYCLE,
  input  wire logic             HARD_RESET,
  input  wire logic             CMD_VALID,
  input  wire logic [7:0]       CMD_OPCODE,
  input  wire logic [1:0]       CMD_CLASS,
  input  wire logic [`PW_W-1:0] CMD_PASSWORD,
  input  wire logic             CMD_PW_MASTER,
  input  wire logic             CMD_LEVEL_MAX,
  input  wire logic [15:0]      CMD_REV_CODE,
  output logic                  RESP_VALID,
  output logic                  RESP_ABORT,
  output logic                  ERASE_ALL,
  output logic                  IRQ,
  input  wire logic [5:0]       S_AXI_AWADDR,
  input  wire logic             S_AXI_AWVALID,
  output logic                  S_AXI_AWREADY,
  input  wire logic [31:0]      S_AXI_WDATA,
  input  wire logic [3:0]       S_AXI_WSTRB,
  input  wire logic             S_AXI_WVALID,
  output logic                  S_AXI_WREADY,
  output logic [1:0]            S_AXI_BRESP,
  output logic                  S_AXI_BVALID,
  input  wire logic             S_AXI_BREADY,
  input  wire logic [5:0]       S_AXI_ARADDR,
  input  wire logic             S_AXI_ARVALID,
  output logic                  S_AXI_ARREADY,
  output logic [31:0]           S_AXI_RDATA,
  output logic [1:0]            S_AXI_RRESP,
  output logic                  S_AXI_RVALID,
  input  wire logic             S_AXI_RREADY
);

  // ==========================================================
  // security state
  lock_pkg::mode_t   mode_q, mode_d;
  logic              lock_en_q, lock_en_d;
  logic              level_max_q, level_max_d;
  logic [`PW_W-1:0]  pw_user_q, pw_user_d;
  logic [`PW_W-1:0]  pw_master_q, pw_master_d;
  logic [15:0]       rev_q, rev_d;
  logic [2:0]        miss_q, miss_d;
  logic              expired_q, expired_d;
  logic              resp_valid_q, resp_valid_d;
  logic              resp_abort_q, resp_abort_d;
  logic              erase_q, erase_d;
  logic [`EV_W-1:0]  ev;

  logic user_ok;
  logic master_ok;
  logic locked;
  logic frozen;

  assign user_ok   = lock_en_q && !CMD_PW_MASTER && CMD_PASSWORD == pw_user_q;
  assign master_ok = CMD_PW_MASTER && CMD_PASSWORD == pw_master_q;
  assign locked    = mode_q == lock_pkg::MODE_LOCKED;
  assign frozen    = mode_q == lock_pkg::MODE_FROZEN;

  always_comb
  begin
    mode_d       = mode_q;
    lock_en_d    = lock_en_q;
    level_max_d  = level_max_q;
    pw_user_d    = pw_user_q;
    pw_master_d  = pw_master_q;
    rev_d        = rev_q;
    miss_d       = miss_q;
    expired_d    = expired_q;
    resp_valid_d = 1'b0;
    resp_abort_d = 1'b0;
    erase_d      = 1'b0;
    ev           = '0;
    if (POWER_CYCLE)
    begin
      // power cycle and RESET are the only ways out of frozen mode
      mode_d    = lock_en_q ? lock_pkg::MODE_LOCKED
                            : lock_pkg::MODE_UNLOCKED;
      miss_d    = 3'h0;
      expired_d = 1'b0;
    end
    else if (HARD_RESET)
    begin
      // frozen survives a hard reset; only power cycle or RESET ends it
      if (!frozen && lock_en_q)
        mode_d = lock_pkg::MODE_LOCKED;
      miss_d    = 3'h0;
      expired_d = 1'b0;
    end
    else if (CMD_VALID)
    begin
      resp_valid_d = 1'b1;
      case (CMD_OPCODE)
        `OP_SET_PW:
        begin
          if (locked || frozen)
            resp_abort_d = 1'b1;
          else if (CMD_PW_MASTER)
          begin
            pw_master_d = CMD_PASSWORD;
            if (CMD_REV_CODE >= `REV_MIN && CMD_REV_CODE <= `REV_MAX)
              rev_d = CMD_REV_CODE;
          end
          else
          begin
            pw_user_d   = CMD_PASSWORD;
            level_max_d = CMD_LEVEL_MAX;
            lock_en_d   = 1'b1;
          end
        end
        `OP_UNLOCK:
        begin
          if (frozen || expired_q)
            resp_abort_d = 1'b1;
          else if (user_ok || (master_ok && !level_max_q))
            mode_d = lock_pkg::MODE_UNLOCKED;
          else if (master_ok)
            resp_abort_d = 1'b1;
          else
          begin
            resp_abort_d = 1'b1;
            ev[`EV_MISMATCH] = 1'b1;
          end
        end
        `OP_ERASE_PREP:
          resp_abort_d = frozen;
        `OP_ERASE_UNIT:
        begin
          if (frozen || expired_q)
            resp_abort_d = 1'b1;
          else if (user_ok || master_ok)
          begin
            erase_d   = 1'b1;
            ev[`EV_ERASED] = 1'b1;
            lock_en_d = 1'b0;
            pw_user_d = `PW_USER_RST;
            mode_d    = lock_pkg::MODE_UNLOCKED;
          end
          else
          begin
            resp_abort_d = 1'b1;
            ev[`EV_MISMATCH] = 1'b1;
          end
        end
        `OP_FREEZE:
        begin
          if (locked)
            resp_abort_d = 1'b1;
          else
            mode_d = lock_pkg::MODE_FROZEN;
        end
        `OP_DISABLE_PW:
        begin
          if (locked || frozen)
            resp_abort_d = 1'b1;
          else if (!lock_en_q || user_ok
                   || (master_ok && !level_max_q))
          begin
            lock_en_d = 1'b0;
            pw_user_d = `PW_USER_RST;
          end
          else
          begin
            resp_abort_d = 1'b1;
            ev[`EV_MISMATCH] = 1'b1;
          end
        end
        default:
        begin
          if (CMD_CLASS == lock_pkg::CLS_RW_LONG)
            resp_abort_d = 1'b1;
          else if (CMD_CLASS == lock_pkg::CLS_MEDIA)
            resp_abort_d = locked;
          else
            resp_abort_d = 1'b0;
        end
      endcase
      // either password mismatching counts alike
      if (ev[`EV_MISMATCH])
      begin
        if (miss_q != `MISMATCH_LIMIT)
          miss_d = miss_q + 3'h1;
        if (miss_q + 3'h1 == `MISMATCH_LIMIT)
        begin
          expired_d = 1'b1;
          ev[`EV_EXPIRED] = 1'b1;
        end
      end
      ev[`EV_ABORT] = resp_abort_d;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      mode_q       <= lock_pkg::MODE_UNLOCKED;
      lock_en_q    <= 1'b0;
      level_max_q  <= 1'b0;
      pw_user_q    <= `PW_USER_RST;
      pw_master_q  <= `PW_MASTER_RST;
      rev_q        <= `REV_DEFAULT;
      miss_q       <= 3'h0;
      expired_q    <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_abort_q <= 1'b0;
      erase_q      <= 1'b0;
    end
    else
    begin
      mode_q       <= mode_d;
      lock_en_q    <= lock_en_d;
      level_max_q  <= level_max_d;
      pw_user_q    <= pw_user_d;
      pw_master_q  <= pw_master_d;
      rev_q        <= rev_d;
      miss_q       <= miss_d;
      expired_q    <= expired_d;
      resp_valid_q <= resp_valid_d;
      resp_abort_q <= resp_abort_d;
      erase_q      <= erase_d;
    end
  end

  assign RESP_VALID = resp_valid_q;
  assign RESP_ABORT = resp_abort_q;
  assign ERASE_ALL  = erase_q;

  // ==========================================================
  // register slave and interrupt
  logic              aw_have_q, aw_have_d;
  logic              w_have_q, w_have_d;
  logic [5:0]        waddr_q, waddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [`EV_W-1:0]  irq_stat_q, irq_stat_d;
  logic [`EV_W-1:0]  irq_mask_q, irq_mask_d;
  logic              irq_q, irq_d;

  function automatic logic known(input logic [5:0] a);
    known = a == `ADDR_STATUS || a == `ADDR_WORD92 || a == `ADDR_WORD128
         || a == `ADDR_IRQ_STAT || a == `ADDR_IRQ_MASK;
  endfunction

  logic do_write;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  always_comb
  begin
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    waddr_d    = waddr_q;
    wdata_d    = wdata_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (S_AXI_AWVALID && !aw_have_q)
    begin
      aw_have_d = 1'b1;
      waddr_d   = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_have_q)
    begin
      w_have_d = 1'b1;
      wdata_d  = S_AXI_WDATA;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = known(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      if (waddr_q == `ADDR_IRQ_MASK)
        irq_mask_d = wdata_q[`EV_W-1:0];
      if (waddr_q == `ADDR_IRQ_STAT)
        irq_stat_d = irq_stat_q & ~wdata_q[`EV_W-1:0];
    end
    if (bvalid_q && S_AXI_BREADY)
      bvalid_d = 1'b0;
    // a new event wins over a clear in the same cycle
    irq_stat_d = irq_stat_d | ev;
    if (S_AXI_ARVALID && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = known(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      case (S_AXI_ARADDR)
        `ADDR_STATUS:   rdata_d = {24'h0, miss_q, expired_q, level_max_q,
                                   lock_en_q, mode_q};
        `ADDR_WORD92:   rdata_d = {16'h0, rev_q};
        `ADDR_WORD128:  rdata_d = 32'(expired_q) << `UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT;
        `ADDR_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
        `ADDR_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
        default:        rdata_d = 32'h0;
      endcase
    end
    else if (rvalid_q && S_AXI_RREADY)
      rvalid_d = 1'b0;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      waddr_q    <= 6'h00;
      wdata_q    <= 32'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= `RESP_OKAY;
      rdata_q    <= 32'h0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
    end
    else
    begin
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
    end
  end

  // ready only while the holding slot is empty
  assign S_AXI_AWREADY = !aw_have_q;
  assign S_AXI_WREADY  = !w_have_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;
  assign IRQ           = irq_q;

endmodule

/* File: src/lock_cfg.svh */
// constants of the drive security lock block
`ifndef LOCK_CFG_SVH
`define LOCK_CFG_SVH

`define OP_SET_PW       8'hf1
`define OP_UNLOCK       8'hf2
`define OP_ERASE_PREP   8'hf3
`define OP_ERASE_UNIT   8'hf4
`define OP_FREEZE       8'hf5
`define OP_DISABLE_PW   8'hf6

`define PW_W            32
`define PW_MASTER_RST   32'h00000000
`define PW_USER_RST     32'h00000000
`define REV_MIN         16'h0001
`define REV_MAX         16'hfffe
`define REV_DEFAULT     16'hfffe
`define MISMATCH_LIMIT  3'h5
`define UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT      4

`define ADDR_STATUS     6'h00
`define ADDR_WORD92     6'h04
`define ADDR_WORD128    6'h08
`define ADDR_IRQ_STAT   6'h0c
`define ADDR_IRQ_MASK   6'h10
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define EV_ABORT        0
`define EV_MISMATCH     1
`define EV_EXPIRED      2
`define EV_ERASED       3
`define EV_W            4

`endif

/* File: src/lock_pkg.sv */
// types of the drive security lock block
package lock_pkg;
  typedef enum logic [1:0] {
    MODE_UNLOCKED,
    MODE_LOCKED,
    MODE_FROZEN
  } mode_t;

  // class of a non-security opcode, supplied by the command decoder
  typedef enum logic [1:0] {
    CLS_ANY,
    CLS_MEDIA,
    CLS_RW_LONG
  } cmd_class_t;
endpackage

/* File: verif/drive_security_lock_fsm_test.sv */
// self-checking bench of the security lock block
`timescale 1ns/1ps
`include "lock_cfg.svh"
// ==========================================================
// bench
module drive_security_lock_fsm_test;
  typedef struct packed {
    logic [1:0] pre;
    logic [7:0] op;
    logic [1:0] cls;
    logic [1:0] pw;
    logic       lv;
    logic [1:0] ex;
  } row_t;
  localparam logic [7:0] RD = 8'h20;
  localparam logic [7:0] SP = `OP_SET_PW;
  localparam logic [7:0] UL = `OP_UNLOCK;
  localparam logic [7:0] PR = `OP_ERASE_PREP;
  localparam logic [7:0] ER = `OP_ERASE_UNIT;
  localparam logic [7:0] FZ = `OP_FREEZE;
  localparam logic [7:0] DS = `OP_DISABLE_PW;
  localparam logic [15:0] REV = 16'h0010;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pc = 1'b0;
  logic        hr = 1'b0;
  logic        cv, cm, cl, rv_c, ab, er, irq;
  logic [7:0]  co;
  logic [1:0]  cc, bresp, rresp, r;
  logic [31:0] cpw, rdata, d;
  logic [15:0] crev;
  logic [5:0]  awa = 6'h00;
  logic [5:0]  ara = 6'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        br = 1'b0;
  logic        arv = 1'b0;
  logic        rr = 1'b0;
  logic        awr, wr, bv, arr, rv;
  logic [2:0]  got;
  int          err_count = 0;
  int          checks_done = 0;
  row_t rows [34] = '{
    '{0, RD, 1, 0, 0, 0}, '{0, RD, 2, 0, 0, 2},
    '{0, SP, 0, 2, 0, 0}, '{1, RD, 1, 0, 0, 0},
    '{0, SP, 0, 1, 0, 0}, '{0, RD, 1, 0, 0, 0},
    '{2, RD, 1, 0, 0, 2}, '{0, RD, 0, 0, 0, 0},
    '{0, PR, 0, 0, 0, 0}, '{0, DS, 0, 1, 0, 2},
    '{0, FZ, 0, 0, 0, 2}, '{0, UL, 0, 2, 0, 0},
    '{1, RD, 1, 0, 0, 2}, '{0, UL, 0, 0, 0, 2},
    '{0, UL, 0, 0, 0, 2}, '{0, UL, 0, 0, 0, 2},
    '{0, UL, 0, 0, 0, 2}, '{0, UL, 0, 0, 0, 2},
    '{0, UL, 0, 1, 0, 2}, '{0, ER, 0, 1, 0, 2},
    '{2, UL, 0, 1, 0, 0}, '{0, SP, 0, 1, 1, 0},
    '{1, UL, 0, 2, 0, 2}, '{0, ER, 0, 2, 0, 1},
    '{1, RD, 1, 0, 0, 0}, '{0, FZ, 0, 0, 0, 0},
    '{0, SP, 0, 1, 0, 2}, '{0, ER, 0, 1, 0, 2},
    '{0, RD, 1, 0, 0, 0}, '{2, DS, 0, 1, 0, 2},
    '{0, FZ, 0, 0, 0, 0}, '{0, RD, 2, 0, 0, 2},
    '{1, SP, 0, 1, 0, 0}, '{0, DS, 0, 1, 0, 0}};
  drive_security_lock_fsm dut_u (.CLK_SYS(clk), .RESET(rst),
    .POWER_CYCLE(pc), .HARD_RESET(hr), .CMD_VALID(cv), .CMD_OPCODE(co),
    .CMD_CLASS(cc), .CMD_PASSWORD(cpw), .CMD_PW_MASTER(cm),
    .CMD_LEVEL_MAX(cl), .CMD_REV_CODE(crev), .RESP_VALID(rv_c),
    .RESP_ABORT(ab), .ERASE_ALL(er), .IRQ(irq), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  host_cmd_model partner_u (.clk_sys(clk), .resp_valid(rv_c),
    .resp_abort(ab), .erase_all(er), .cmd_valid(cv), .cmd_opcode(co),
    .cmd_class(cc), .cmd_password(cpw), .cmd_pw_master(cm),
    .cmd_level_max(cl), .cmd_rev_code(crev));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic hang(input logic ok);
    if (!ok)
    begin
      chk("answer", 32'h1, 32'h0);
      summarize();
    end
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      n++;
    end
    while (bv !== 1'b1 && n < 40);
    hang(bv === 1'b1);
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic axr(input logic [5:0] a);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end
    while (rv !== 1'b1 && n < 40);
    hang(rv === 1'b1);
    d = rdata;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic pulse(input logic [1:0] k);
    @(posedge clk);
    pc <= k[0];
    hr <= k[1];
    @(posedge clk);
    pc <= 1'b0;
    hr <= 1'b0;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    axr(`ADDR_STATUS);
    chk("status", 32'h0, d);
    axr(`ADDR_WORD92);
    chk("revision", 32'h0000fffe, d);
    foreach (rows[i])
    begin
      if (rows[i].pre != 2'd0) pulse(rows[i].pre);
      partner_u.issue(rows[i].op, rows[i].cls, rows[i].pw == 2'd1 ?
        32'h1234 : rows[i].pw == 2'd2 ? 32'h5a5a : 32'hbad,
        rows[i].pw == 2'd2, rows[i].lv, REV, got);
      chk("response", {29'h0, 1'b1, rows[i].ex}, {29'h0, got});
    end
    $display("table done");
    // an out-of-range code must leave the stored one
    partner_u.issue(SP, 2'd0, 32'h5a5a, 1'b1, 1'b0, 16'hffff, got);
    axr(`ADDR_WORD92);
    chk("revision", {16'h0, REV}, d);
    pulse(2'd2);
    repeat (6) partner_u.issue(UL, 2'd0, 32'h77, 1'b0, 1'b0, REV, got);
    axr(`ADDR_STATUS);
    chk("count", 32'hb, {28'h0, d[7:4]});
    axr(`ADDR_WORD128);
    chk("word128", 32'h10, d);
    pulse(2'd2);
    axr(`ADDR_WORD128);
    chk("word128", 32'h0, d);
    $display("expiry done");
    axr(6'h3c);
    chk("rresp", 32'h2, {30'h0, r});
    axw(6'h3c, 32'h1);
    chk("bresp", 32'h2, {30'h0, r});
    // abort, mismatch, expiry and erase have all fired by now
    axr(`ADDR_IRQ_STAT);
    chk("irq status", 32'hf, d);
    axw(`ADDR_IRQ_STAT, 32'hf);
    axw(`ADDR_IRQ_MASK, 32'h0);
    partner_u.issue(RD, 2'd2, 32'h0, 1'b0, 1'b0, REV, got);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    axr(`ADDR_IRQ_STAT);
    chk("irq status", 32'h1, d);
    axw(`ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    axw(`ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("interrupt done");
    summarize();
  end
endmodule

/* File: verif/host_cmd_model.sv */
// host side model issuing commands to the lock block
`timescale 1ns/1ps
`include "lock_cfg.svh"
// ==========================================================
// command issuer
module host_cmd_model (
  input  wire logic        clk_sys,
  input  wire logic        resp_valid,
  input  wire logic        resp_abort,
  input  wire logic        erase_all,
  output logic             cmd_valid,
  output logic [7:0]       cmd_opcode,
  output logic [1:0]       cmd_class,
  output logic [`PW_W-1:0] cmd_password,
  output logic             cmd_pw_master,
  output logic             cmd_level_max,
  output logic [15:0]      cmd_rev_code
);
  initial
  begin
    {cmd_valid, cmd_opcode, cmd_class, cmd_password} = '0;
    {cmd_pw_master, cmd_level_max, cmd_rev_code} = '0;
  end
  // one command, answer sampled the cycle after it stands
  task automatic issue(input logic [7:0] op, input logic [1:0] cls,
    input logic [`PW_W-1:0] pw, input logic m, input logic lv,
    input logic [15:0] rev, output logic [2:0] got);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_class <= cls;
    cmd_password <= pw;
    cmd_pw_master <= m;
    cmd_level_max <= lv;
    cmd_rev_code <= rev;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    // a released field must not keep looking valid
    cmd_password <= ~pw;
    @(posedge clk_sys);
    got = {resp_valid, resp_abort, erase_all};
  endtask
endmodule

/* File: verif/lock_fsm_asserts.sv */
// checker of the security lock block ports
`timescale 1ns/1ps
`include "lock_cfg.svh"
// ==========================================================
// properties
module lock_fsm_asserts (
  input wire logic       CLK_SYS,
  input wire logic       RESET,
  input wire logic       POWER_CYCLE,
  input wire logic       HARD_RESET,
  input wire logic       CMD_VALID,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [1:0] CMD_CLASS,
  input wire logic       RESP_VALID,
  input wire logic       RESP_ABORT,
  input wire logic       ERASE_ALL
);
  logic [7:0] op_q;
  logic       frz_q;
  logic       frz_d;
  logic       take;
  logic       sec;
  assign take = CMD_VALID && !POWER_CYCLE && !HARD_RESET;
  assign sec = CMD_OPCODE inside {[`OP_SET_PW:`OP_DISABLE_PW]};
  // hard reset must not leave frozen, so only these two clear it
  always_comb
  begin
    frz_d = frz_q;
    if (RESP_VALID && !RESP_ABORT && op_q == `OP_FREEZE)
      frz_d = 1'b1;
    if (RESET || POWER_CYCLE)
      frz_d = 1'b0;
  end
  always_ff @(posedge CLK_SYS)
  begin
    op_q  <= CMD_OPCODE;
    frz_q <= frz_d;
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  property p_answer;
    take |=> RESP_VALID;
  endproperty
  a_answer: assert property (p_answer) else $error("no response");
  property p_quiet;
    !take |=> !RESP_VALID;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray response");
  property p_long;
    take && !sec && CMD_CLASS == lock_pkg::CLS_RW_LONG |=> RESP_ABORT;
  endproperty
  a_long: assert property (p_long) else $error("long ran");
  property p_frz_gate;
    take && frz_q && sec && CMD_OPCODE != `OP_FREEZE |=> RESP_ABORT;
  endproperty
  a_frz_gate: assert property (p_frz_gate) else $error("frozen ran");
  property p_frz_again;
    take && frz_q && CMD_OPCODE == `OP_FREEZE |=> !RESP_ABORT;
  endproperty
  a_frz_again: assert property (p_frz_again) else $error("refreeze");
  property p_frz_runs;
    take && frz_q && !sec && CMD_CLASS inside {lock_pkg::CLS_ANY,
      lock_pkg::CLS_MEDIA} |=> !RESP_ABORT;
  endproperty
  a_frz_runs: assert property (p_frz_runs) else $error("frz abort");
  property p_erase_ok;
    ERASE_ALL |-> RESP_VALID && !RESP_ABORT;
  endproperty
  a_erase_ok: assert property (p_erase_ok) else $error("bad erase");
  property p_erase_op;
    ERASE_ALL |-> op_q == `OP_ERASE_UNIT;
  endproperty
  a_erase_op: assert property (p_erase_op) else $error("erase op");
endmodule

bind drive_security_lock_fsm lock_fsm_asserts chk_u (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .POWER_CYCLE(POWER_CYCLE),
  .HARD_RESET(HARD_RESET), .CMD_VALID(CMD_VALID),
  .CMD_OPCODE(CMD_OPCODE), .CMD_CLASS(CMD_CLASS),
  .RESP_VALID(RESP_VALID), .RESP_ABORT(RESP_ABORT), .ERASE_ALL(ERASE_ALL)
);
